// *** logic/bfsc_core.sv ***
// Bus fault cause flags with address valid, readable and write-one-to-clear.
// Assumes fault events arrive as one-cycle strobes from the exception sequencer.
// Assumes register requests are levels sampled at the rising clock edge.
//
// Function
// - Set the address valid flag whenever a bus fault with a known address occurs.
// - Clear the address valid flag when a later, different fault occurs.
// - Set the lazy save flag only for a bus fault during lazy floating-point preservation.
// - Set the entry stacking flag when context push faults.
// - On stacking fault still adjust the stack pointer and capture no address.
// - Set the return unstacking flag when context pop faults.
// - On unstacking fault chain to handler, keep stack, no save and no address.
// - Set the async data flag for imprecise data errors and capture no address.
// - Async errors at higher execution priority become pending until priority drops.
// - A sync fault before the pending async handler leaves both flags set.
// - Set the sync data flag and capture the faulting address.
// - Set the fetch flag only on issue of the faulting instruction, with no address.
// - All flags are sticky and cleared by writing one or by reset; the address valid flag also clears on a later, different fault.
// - The byte is reachable at its own byte address and within the combined word.
`timescale 1ns/1ns
module bfsc_core
(
  input wire logic clk,
  input wire logic arst_n,
  input bfsc_pkg::bfsc_evt_t evt,
  input wire logic exec_prio_above_bus,
  input bfsc_pkg::bfsc_req_t req,
  output logic [31:0] rdata,
  output logic [7:0] bus_fault_cause_flags,
  output logic [31:0] bus_fault_address_reg,
  output logic bus_fault_pending,
  output logic bus_fault_activate,
  output logic sp_adjust,
  output logic chain_to_handler
);
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] set_vec;
  logic [7:0] hw_clr_vec;
  logic [7:0] sw_clr_vec;
  logic [7:0] flags;
  logic [31:0] next_addr;
  logic next_pending;
  logic [31:0] next_rdata;
  logic rd_hit;
  logic wr_hit;
  logic next_activate;
  logic next_sp_adjust;
  logic next_chain;

  // Address decode
  bfsc_decode u_dec
  (
    .req(req),
    .hit(hit),
    .wbyte(wbyte)
  );

  // Per-bit set and clear strobes
  always_comb
  begin
    set_vec = 8'h00;
    hw_clr_vec = 8'h00;
    sw_clr_vec = 8'h00;
    if (evt.ifetch_issue_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_IBUS] = 1'h1;
    end
    if (evt.sync_data_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_SYNC] = 1'h1;
      set_vec[bfsc_pkg::BFSC_BIT_VALID] = 1'h1;
    end
    if (evt.async_data_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_ASYNC] = 1'h1;
    end
    if (evt.unstack_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_UNSTK] = 1'h1;
    end
    if (evt.stack_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_STK] = 1'h1;
    end
    if (evt.lazy_fp_err)
    begin
      set_vec[bfsc_pkg::BFSC_BIT_LSP] = 1'h1;
    end
    if (evt.other_fault)
    begin
      hw_clr_vec[bfsc_pkg::BFSC_BIT_VALID] = 1'h1;
    end
    if (wr_hit)
    begin
      sw_clr_vec = wbyte & bfsc_pkg::BFSC_IMPL_MASK;
    end
  end

  // One sticky flag per implemented bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (gi == bfsc_pkg::BFSC_BIT_RSVD)
      begin : g_rsvd
        assign flags[gi] = 1'b0;
      end
      else
      begin : g_bit
        logic bit_set;
        logic bit_hw_clr;
        logic bit_sw_clr;
        assign bit_set = set_vec[gi];
        assign bit_hw_clr = hw_clr_vec[gi];
        assign bit_sw_clr = sw_clr_vec[gi];
        bfsc_w1c_bit u_bit
        (
          .clk(clk),
          .arst_n(arst_n),
          .set(bit_set),
          .hw_clr(bit_hw_clr),
          .sw_clr(bit_sw_clr),
          .flag(flags[gi])
        );
      end
    end
  endgenerate

  assign bus_fault_cause_flags = flags;

  // Read and write strobes
  always_comb
  begin
    rd_hit = 1'h0;
    wr_hit = 1'h0;
    if (hit)
    begin
      if (req.wr)
      begin
        wr_hit = 1'h1;
      end
      else
      begin
        rd_hit = 1'h1;
      end
    end
  end

  // Read data in the lane of the access size
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd_hit)
    begin
      case (req.size)
        bfsc_pkg::BFSC_SZ_BYTE:
        begin
          next_rdata[7:0] = flags;
        end
        bfsc_pkg::BFSC_SZ_HALF:
        begin
          next_rdata[15:8] = flags;
        end
        bfsc_pkg::BFSC_SZ_WORD:
        begin
          next_rdata[15:8] = flags;
        end
        default:
        begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Fault address capture, sync data errors only
  always_comb
  begin
    next_addr = bus_fault_address_reg;
    if (evt.sync_data_err)
    begin
      next_addr = evt.sync_addr;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_fault_address_reg <= bfsc_pkg::BFSC_ADDR_RESET;
    end
    else
    begin
      bus_fault_address_reg <= next_addr;
    end
  end

  // Async errors held back behind higher priority
  always_comb
  begin
    next_pending = bus_fault_pending;
    if (evt.async_data_err && exec_prio_above_bus)
    begin
      next_pending = 1'h1;
    end
    else if (bus_fault_pending && !exec_prio_above_bus)
    begin
      next_pending = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_fault_pending <= 1'h0;
    end
    else
    begin
      bus_fault_pending <= next_pending;
    end
  end

  // Activation once priority allows
  always_comb
  begin
    next_activate = 1'h0;
    if (!exec_prio_above_bus && (bus_fault_pending || evt.async_data_err))
    begin
      next_activate = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_fault_activate <= 1'h0;
    end
    else
    begin
      bus_fault_activate <= next_activate;
    end
  end

  // Stack pointer still moves on a stacking fault
  always_comb
  begin
    next_sp_adjust = 1'h0;
    if (evt.stack_err)
    begin
      next_sp_adjust = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sp_adjust <= 1'h0;
    end
    else
    begin
      sp_adjust <= next_sp_adjust;
    end
  end

  // Unstacking fault chains straight to the handler
  always_comb
  begin
    next_chain = 1'h0;
    if (evt.unstack_err)
    begin
      next_chain = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chain_to_handler <= 1'h0;
    end
    else
    begin
      chain_to_handler <= next_chain;
    end
  end
endmodule

// *** logic/bfsc_decode.sv ***
// Decodes a system control space access into a hit and the write data byte, taken from bits 15:8, or from bits 7:0 for a byte access.
// Assumes accesses are naturally aligned.
`timescale 1ns/1ns
module bfsc_decode
(
  input bfsc_pkg::bfsc_req_t req,
  output logic hit,
  output logic [7:0] wbyte
);
  always_comb
  begin
    hit = 1'b0;
    wbyte = req.wdata[15:8];
    if (req.sel)
    begin
      case (req.size)
        bfsc_pkg::BFSC_SZ_BYTE:
        begin
          hit = (req.addr == bfsc_pkg::BFSC_CAUSE_BYTE_ADDR);
          wbyte = req.wdata[7:0];
        end
        bfsc_pkg::BFSC_SZ_HALF:
        begin
          hit = (req.addr == bfsc_pkg::BFSC_STATUS_WORD_ADDR);
        end
        bfsc_pkg::BFSC_SZ_WORD:
        begin
          hit = (req.addr == bfsc_pkg::BFSC_STATUS_WORD_ADDR);
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
    end
  end
endmodule

// *** logic/bfsc_w1c_bit.sv ***
// One sticky status flag: hardware set, software write-one-to-clear, optional hardware clear.
// Assumes set and clear are single-cycle strobes on clk.
`timescale 1ns/1ns
module bfsc_w1c_bit
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic set,
  input wire logic hw_clr,
  input wire logic sw_clr,
  output logic flag
);
  logic next_flag;

  always_comb
  begin
    next_flag = flag;
    if (sw_clr || hw_clr)
    begin
      next_flag = 1'b0;
    end
    if (set)
    begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
    end
  end
endmodule

// *** pkg/bfsc_pkg.sv ***
// Package for bus fault status capture: field positions, access codes, event carriers.
// Assumes the system control space decodes to a byte address within the fault status word.
package bfsc_pkg;
  localparam logic [31:0] BFSC_STATUS_WORD_ADDR = 32'he000ed28;
  localparam logic [31:0] BFSC_CAUSE_BYTE_ADDR = 32'he000ed29;
  localparam int BFSC_BYTE_LANE = 1;
  localparam int BFSC_BIT_IBUS = 0;
  localparam int BFSC_BIT_SYNC = 1;
  localparam int BFSC_BIT_ASYNC = 2;
  localparam int BFSC_BIT_UNSTK = 3;
  localparam int BFSC_BIT_STK = 4;
  localparam int BFSC_BIT_LSP = 5;
  localparam int BFSC_BIT_RSVD = 6;
  localparam int BFSC_BIT_VALID = 7;
  localparam logic [7:0] BFSC_RESET_VALUE = 8'h00;
  localparam logic [7:0] BFSC_IMPL_MASK = 8'hbf;
  localparam logic [31:0] BFSC_ADDR_RESET = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    BFSC_SZ_BYTE,
    BFSC_SZ_HALF,
    BFSC_SZ_WORD
  } bfsc_size_t;

  typedef struct packed
  {
    logic ifetch_issue_err;
    logic sync_data_err;
    logic async_data_err;
    logic unstack_err;
    logic stack_err;
    logic lazy_fp_err;
    logic [31:0] sync_addr;
    logic other_fault;
  } bfsc_evt_t;

  typedef struct packed
  {
    logic sel;
    logic wr;
    bfsc_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bfsc_req_t;
endpackage

// *** verif/bfsc_bench.sv ***
// Bench for the bus fault cause flags.
// Assumes core, sequencer model and checker are compiled first.
`timescale 1ns/1ns
module bfsc_bench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic prio = 1'h0;
  bfsc_pkg::bfsc_req_t req = '0;
  bfsc_pkg::bfsc_evt_t evt;
  logic [31:0] rdata, addr;
  logic [7:0] flags;
  logic pend, act, spa, chn;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  bfsc_seq_model i_bfsc_seq_model (.clk, .evt);
  bfsc_core i_bfsc_core (.clk, .arst_n, .evt, .exec_prio_above_bus(prio), .req, .rdata,
    .bus_fault_cause_flags(flags), .bus_fault_address_reg(addr), .bus_fault_pending(pend),
    .bus_fault_activate(act), .sp_adjust(spa), .chain_to_handler(chn));
  task automatic chk(input string n, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic acc(input bfsc_pkg::bfsc_size_t s, input logic [31:0] a, d, input logic w);
    @(posedge clk);
    req <= '{1'h1, w, s, a, d};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
  endtask
  task automatic ev(input int k, input logic [31:0] a);
    i_bfsc_seq_model.raise(k, a);
    @(negedge clk);
  endtask
  task automatic t_map();
    int ks[5] = '{0, 2, 3, 4, 5};
    logic [7:0] e = 8'h00;
    chk("flags", flags, 8'h00);
    foreach (ks[i])
    begin
      ev(ks[i], 32'h0);
      e[ks[i]] = 1'h1;
      chk("flags", flags, e);
      chk("sp", spa, ks[i] == 4);
      chk("chain", chn, ks[i] == 3);
    end
    acc(bfsc_pkg::BFSC_SZ_BYTE, 32'he000ed29, 32'h0, 1'h0);
    chk("byte", rdata, 32'h3d);
    acc(bfsc_pkg::BFSC_SZ_WORD, 32'he000ed28, 32'h0, 1'h0);
    chk("word", rdata[15:8], 8'h3d);
    acc(bfsc_pkg::BFSC_SZ_BYTE, 32'he000ed2c, 32'hff, 1'h1);
    chk("unmapped", rdata, 32'h0);
    chk("flags", flags, 8'h3d);
    acc(bfsc_pkg::BFSC_SZ_HALF, 32'he000ed28, 32'h2100, 1'h1);
    chk("flags", flags, 8'h1c);
    acc(bfsc_pkg::BFSC_SZ_BYTE, 32'he000ed29, 32'hff, 1'h1);
    chk("flags", flags, 8'h00);
  endtask
  task automatic t_valid();
    ev(1, 32'h1234_5678);
    chk("addr", addr, 32'h1234_5678);
    chk("flags", flags, 8'h82);
    ev(6, 32'h0);
    chk("flags", flags, 8'h02);
    ev(1, 32'h0000_0ab0);
    acc(bfsc_pkg::BFSC_SZ_BYTE, 32'he000ed29, 32'h80, 1'h1);
    chk("flags", flags, 8'h02);
    chk("addr", addr, 32'h0000_0ab0);
  endtask
  task automatic t_pend();
    int i = 0;
    @(posedge clk) prio <= 1'h1;
    ev(2, 32'h0);
    chk("pend", pend, 1'h1);
    chk("act", act, 1'h0);
    ev(1, 32'h40);
    chk("flags", flags, 8'h86);
    chk("addr", addr, 32'h0000_0040);
    @(posedge clk) prio <= 1'h0;
    while (act !== 1'h1 && i < 4)
    begin
      @(negedge clk);
      i++;
    end
    chk("act", act, 1'h1);
  endtask
  task automatic t_reset();
    ev(4, 32'h0);
    @(posedge clk) arst_n <= 1'h0;
    @(negedge clk);
    chk("flags", flags, 8'h00);
    chk("addr", addr, 32'h0);
    chk("sp", spa, 1'h0);
    @(posedge clk) arst_n <= 1'h1;
    ev(3, 32'h0);
    chk("flags", flags, 8'h08);
    chk("chain", chn, 1'h1);
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    t_map();
    t_valid();
    t_pend();
    t_reset();
    end_sim();
  end
endmodule
bind bfsc_core bfsc_core_chk i_bfsc_core_chk (.clk, .arst_n, .evt, .exec_prio_above_bus, .req,
  .bus_fault_cause_flags, .bus_fault_address_reg, .bus_fault_pending, .bus_fault_activate,
  .sp_adjust, .chain_to_handler);

// *** verif/bfsc_core_chk.sv ***
// Checker for the bus fault cause flags.
// Assumes it is bound to bfsc_core.
`timescale 1ns/1ns
module bfsc_core_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input bfsc_pkg::bfsc_evt_t evt,
  input wire logic exec_prio_above_bus,
  input bfsc_pkg::bfsc_req_t req,
  input wire logic [7:0] bus_fault_cause_flags,
  input wire logic [31:0] bus_fault_address_reg,
  input wire logic bus_fault_pending,
  input wire logic bus_fault_activate,
  input wire logic sp_adjust,
  input wire logic chain_to_handler
);
  wire [7:0] f = bus_fault_cause_flags;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_sync_capture: assert property (
    evt.sync_data_err |=> f[1] && f[7] && bus_fault_address_reg == $past(evt.sync_addr))
    else $error("sync capture");
  chk_stack_entry: assert property (
    evt.stack_err && !evt.sync_data_err |=> f[4] && sp_adjust && $stable(bus_fault_address_reg))
    else $error("stacking fault");
  chk_unstack_chain: assert property (
    evt.unstack_err && !evt.sync_data_err |=> f[3] && chain_to_handler && $stable(bus_fault_address_reg))
    else $error("unstacking fault");
  chk_plain_flags: assert property (
    1'h1 |=> f[0] >= $past(evt.ifetch_issue_err) && f[2] >= $past(evt.async_data_err)
    && f[5] >= $past(evt.lazy_fp_err)) else $error("flag not set");
  chk_reserved_zero: assert property (!f[6]) else $error("bit 6 set");
  chk_flags_sticky: assert property (
    !(req.sel && req.wr) && !evt.other_fault |=> (f & $past(f)) == $past(f))
    else $error("flag lost");
  chk_valid_drop: assert property (
    evt.other_fault && !evt.sync_data_err |=> !f[7]) else $error("valid kept");
  chk_async_pending: assert property (
    evt.async_data_err && exec_prio_above_bus |=> bus_fault_pending && !bus_fault_activate)
    else $error("pending wrong");
  chk_no_addr_load: assert property (
    (evt.async_data_err || evt.ifetch_issue_err || evt.lazy_fp_err) && !evt.sync_data_err
    |=> $stable(bus_fault_address_reg)) else $error("address loaded");
  chk_pend_release: assert property (
    bus_fault_pending && !exec_prio_above_bus |=> bus_fault_activate && !bus_fault_pending)
    else $error("pending not released");
endmodule

// *** verif/bfsc_seq_model.sv ***
// Exception sequencer model: one-cycle fault strobes.
// Assumes the bench calls raise away from a clock edge.
`timescale 1ns/1ns
module bfsc_seq_model
(
  input wire logic clk,
  output bfsc_pkg::bfsc_evt_t evt
);
  initial evt = '0;
  // Kind is the flag bit index, 6 a later non-bus fault
  task automatic raise(input int k, input logic [31:0] a);
    logic [6:0] m;
    m = 7'h01 << k;
    @(posedge clk);
    evt <= '{m[0], m[1], m[2], m[3], m[4], m[5], a, m[6]};
    @(posedge clk);
    evt <= {6'h00, ~a, 1'h0};
  endtask
endmodule
